// ===== hbt_bridge_ctrl.sv
`timescale 1ns/1ps
// What this block does
// RL1: two inputs, disable and bridge, set output
// RL2: undriven inputs default to output high impedance
// RL3: non-overlap gap between high and low switch
// RL4: no sleep pin means sleep inactive
// RL5: overrides count only after unlock key written
// RL6: select zero merges pin and override by OR
// RL7: select one merges pin and override by AND
// RL8: sleep comes only from the sleep pin
// RL9: hardwired slope pin latched once at init
// RL10: serial slope bits apply at once, eight steps
// RL11: optional spread oscillator, triangle, twelve percent
// RL12: off-hold fixed 30us or selectable 20-50us
// RL13: trip forces low only while high side on
// RL14: input change ends the off-hold interval at once
// RL15: trip ignored while output slewing
// RL16: extra blanking after leaving low-side recirculation; code loads the same blanking count
// RL17: six trip levels hardwired, eight serial
// RL18: hardwired trip level pin is transparent
// RL19: serial trip level bits apply at once
// RL20: trip sets sticky flag, no fault pin
// RL21: high-side load setting masks trip regulation
// RL22: status cleared by clear command or sleep
// RL23: off-hold timed by counter, restarts, clears
module hbt_bridge_ctrl #(
    parameter bit SERIAL_VARIANT = 1'b1,
    parameter bit HAS_SLEEP_PIN = 1'b1
)(
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // control pins, already resolved with their pull defaults
    input wire logic sleep_request_pin,
    input wire logic drive_disable_pin,
    input wire logic bridge_in_pin,
    // hardwired settings pins
    input wire logic [2:0] output_slope_setting,
    input wire logic [2:0] trip_level_setting,
    input wire logic hs_load_pin,
    // analog feedback
    input wire logic trip_comparator,
    input wire logic high_gate_on,
    input wire logic low_gate_on,
    // bridge and analog controls
    output logic high_switch_en,
    output logic low_switch_en,
    output hbt_pkg::hbt_out_e bridge_state,
    output logic [2:0] slope_select,
    output logic [2:0] trip_level_select,
    output logic osc_tick,
    output logic trip_compare_flag
);
    import hbt_pkg::*;

    logic [31:0] output_config_register, protection_config_register;
    logic [1:0] override_reg;
    logic unlocked_reg, trip_flag_reg, hold_reg;
    logic [2:0] hw_slope_reg;
    logic init_done_reg;
    logic [HBT_CNT_W-1:0] hold_cnt_reg, blank_cnt_reg;
    hbt_ctl_s ctl, ctl_prev_reg;
    hbt_out_e cmd_state, state_reg;
    logic sleeping, wr_en, rd_en, clr_cmd;
    logic [HBT_CNT_W-1:0] hold_cycles;
    logic sensing_ok, trip_event, ctl_change;
    logic [7:0] tri_reg, osc_cnt_reg;
    logic tri_up_reg;
    logic [7:0] osc_div;

    // merge a pin with its override: or when select low, and when high
    function automatic logic merge(input logic pin, input logic ovr, input logic sel,
                                   input logic en);
        if (!en)
            merge = pin;
        else if (sel)
            merge = pin & ovr; // see RL7
        else
            merge = pin | ovr; // see RL6
    endfunction

    // apb decode, zero wait states
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign clr_cmd = wr_en && paddr == HBT_CMD_OFF && pwdata[HBT_CLR_BIT];
    // no sleep pin means sleep is held inactive
    assign sleeping = HAS_SLEEP_PIN ? ~sleep_request_pin : 1'b0; // see RL4, RL8

    // command and override registers; sleep relocks the override path
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            unlocked_reg <= 1'b0;
            override_reg <= 2'h0;
        end
        else if (sleeping)
        begin
            unlocked_reg <= 1'b0;
            override_reg <= 2'h0;
        end
        else if (wr_en)
        begin
            if (paddr == HBT_CMD_OFF)
                unlocked_reg <= SERIAL_VARIANT &&
                    pwdata[HBT_UNLOCK_LSB +: HBT_UNLOCK_W] == HBT_UNLOCK_KEY; // see RL5
            if (paddr == HBT_OVR_OFF)
                override_reg <= {pwdata[HBT_OVR_IN_BIT], pwdata[HBT_OVR_DIS_BIT]};
        end
    end

    // configuration registers, take effect the cycle after the write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            output_config_register <= HBT_OUTCFG_RST;
            protection_config_register <= HBT_PROTCFG_RST;
        end
        else if (wr_en && SERIAL_VARIANT)
        begin
            if (paddr == HBT_OUTCFG_OFF)
                output_config_register <= pwdata; // see RL10
            if (paddr == HBT_PROTCFG_OFF)
                protection_config_register <= pwdata; // see RL19
        end
    end

    // hardwired slope pin caught once after reset or wake
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            init_done_reg <= 1'b0;
            hw_slope_reg <= 3'h0;
        end
        else if (sleeping)
            init_done_reg <= 1'b0;
        else if (!init_done_reg)
        begin
            init_done_reg <= 1'b1;
            hw_slope_reg <= output_slope_setting; // see RL9
        end
    end

    // slope and trip selections; serial has 8 levels, pins use 6
    assign slope_select = SERIAL_VARIANT ?
        output_config_register[HBT_SLOPE_LSB +: HBT_SLOPE_W] : hw_slope_reg;
    assign trip_level_select = SERIAL_VARIANT ?
        protection_config_register[HBT_TRIP_LSB +: HBT_TRIP_W] :
        trip_level_setting; // see RL17, RL18

    // effective inputs
    assign ctl.drive_disable = merge(drive_disable_pin, override_reg[HBT_OVR_DIS_BIT],
        protection_config_register[HBT_DIS_SEL_BIT], unlocked_reg);
    assign ctl.bridge_in = merge(bridge_in_pin, override_reg[HBT_OVR_IN_BIT],
        protection_config_register[HBT_IN_SEL_BIT], unlocked_reg);

    // truth table: sleep or disable -> hiz, else follows bridge input
    always_comb
    begin
        if (sleeping || ctl.drive_disable)
            cmd_state = HBT_OUT_HIZ; // see RL1, RL2
        else if (ctl.bridge_in)
            cmd_state = HBT_OUT_HIGH;
        else
            cmd_state = HBT_OUT_LOW;
    end

    // off-hold length in cycles
    assign hold_cycles = SERIAL_VARIANT ?
        HBT_CNT_W'((HBT_OFF_HOLD_INTERVAL_MIN_US + HBT_OFF_HOLD_INTERVAL_STEP_US *
        int'(output_config_register[HBT_OFF_HOLD_INTERVAL_LSB +: HBT_OFF_HOLD_INTERVAL_W])) * HBT_CLK_MHZ) :
        HBT_CNT_W'(HBT_OFF_HOLD_INTERVAL_HW_US * HBT_CLK_MHZ); // see RL12

    assign ctl_change = ctl != ctl_prev_reg;
    // sensing valid: high side fully on, blanking over, not high-side load
    assign sensing_ok = state_reg == HBT_OUT_HIGH && high_gate_on &&
        blank_cnt_reg == '0; // see RL13, RL15
    assign trip_event = trip_comparator && sensing_ok && !hold_reg && !ctl_change &&
        !(SERIAL_VARIANT ? protection_config_register[HBT_HSLOAD_BIT] :
        hs_load_pin); // see RL21

    // blanking after each high-side turn-on; same count when leaving low-side recirculation
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            blank_cnt_reg <= '0;
        else if (state_reg == HBT_OUT_HIGH && !high_gate_on)
            blank_cnt_reg <= HBT_CNT_W'(HBT_BLANK_CYC); // see RL15, RL16
        else if (blank_cnt_reg != '0)
            blank_cnt_reg <= blank_cnt_reg - 1'b1;
    end

    // off-hold timer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hold_reg <= 1'b0;
            hold_cnt_reg <= '0;
            ctl_prev_reg <= '0;
        end
        else
        begin
            ctl_prev_reg <= ctl;
            if (ctl_change || sleeping)
            begin
                hold_reg <= 1'b0; // see RL14, RL23
                hold_cnt_reg <= '0;
            end
            else if (trip_event)
            begin
                hold_reg <= 1'b1; // see RL13, RL23
                hold_cnt_reg <= hold_cycles;
            end
            else if (hold_reg)
            begin
                hold_cnt_reg <= hold_cnt_reg - 1'b1;
                if (hold_cnt_reg == HBT_CNT_W'(1))
                    hold_reg <= 1'b0;
            end
        end
    end

    // sticky trip flag, set wins over clear, no fault pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            trip_flag_reg <= 1'b0;
        else if (trip_event && SERIAL_VARIANT)
            trip_flag_reg <= 1'b1; // see RL20
        else if (clr_cmd || sleeping)
            trip_flag_reg <= 1'b0; // see RL22
    end
    assign trip_compare_flag = trip_flag_reg;

    // bridge state; low drive forced during hold
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_reg <= HBT_OUT_HIZ;
        else if (hold_reg && !ctl_change && cmd_state == HBT_OUT_HIGH)
            state_reg <= HBT_OUT_LOW;
        else
            state_reg <= cmd_state;
    end
    assign bridge_state = state_reg;

    // gate enables: wait for the opposite gate to be off first
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            high_switch_en <= 1'b0;
            low_switch_en <= 1'b0;
        end
        else
        begin
            high_switch_en <= state_reg == HBT_OUT_HIGH && !low_gate_on &&
                !low_switch_en; // see RL3
            low_switch_en <= state_reg == HBT_OUT_LOW && !high_gate_on &&
                !high_switch_en; // see RL3
        end
    end

    // spread oscillator: divider swept by a triangle, off gives nominal rate
    assign osc_div = output_config_register[HBT_SPREAD_BIT] && SERIAL_VARIANT ?
        8'(HBT_OSC_NOM - HBT_OSC_DEV) + tri_reg : 8'(HBT_OSC_NOM);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tri_reg <= 8'h00;
            tri_up_reg <= 1'b1;
            osc_cnt_reg <= 8'h00;
            osc_tick <= 1'b0;
        end
        else
        begin
            // triangle across 2*dev, one step per oscillator tick
            if (tri_up_reg && tri_reg >= 8'(2 * HBT_OSC_DEV))
                tri_up_reg <= 1'b0;
            else if (!tri_up_reg && tri_reg == 8'h00)
                tri_up_reg <= 1'b1;
            else if (osc_cnt_reg == 8'h00)
                tri_reg <= tri_up_reg ? tri_reg + 8'h01 : tri_reg - 8'h01; // see RL11
            osc_tick <= osc_cnt_reg == 8'h00;
            osc_cnt_reg <= osc_cnt_reg == 8'h00 ? osc_div - 8'h01 : osc_cnt_reg - 8'h01;
        end
    end

    // read data registered in setup phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (rd_en)
        begin
            unique case (paddr)
                HBT_CMD_OFF: prdata <= 32'h00000000;
                HBT_OVR_OFF: prdata <= {30'h0, override_reg};
                HBT_OUTCFG_OFF: prdata <= output_config_register;
                HBT_PROTCFG_OFF: prdata <= protection_config_register;
                HBT_STAT_OFF: prdata <= {29'h0, unlocked_reg, hold_reg, trip_flag_reg};
                default: prdata <= 32'h00000000;
            endcase
        end
    end
endmodule

// ===== hbt_bridge_ctrl_sva.sv
`timescale 1ns/1ps
module hbt_bridge_ctrl_sva
    import hbt_pkg::*;
#(
    parameter bit SERIAL_VARIANT = 1'b1,
    parameter bit HAS_SLEEP_PIN = 1'b1
)(
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins and bridge
    input wire logic sleep_request_pin,
    input wire logic trip_comparator,
    input wire logic high_switch_en,
    input wire logic low_switch_en,
    input wire hbt_pkg::hbt_out_e bridge_state,
    input wire logic [2:0] slope_select,
    input wire logic [2:0] trip_level_select,
    input wire logic trip_compare_flag
);
    logic wr_acc;
    logic clr_wr;
    // completed write and fault clear request
    assign wr_acc = psel && penable && pwrite;
    assign clr_wr = wr_acc && paddr == HBT_CMD_OFF && pwdata[HBT_CLR_BIT];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_no_overlap;
        !(high_switch_en && low_switch_en);
    endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("both switches enabled");
    property p_sleep_hiz;
        HAS_SLEEP_PIN && !sleep_request_pin [*2] |-> bridge_state == HBT_OUT_HIZ;
    endproperty
    a_sleep_hiz: assert property (p_sleep_hiz)
        else $error("output not off in sleep");
    property p_hiz_off;
        bridge_state == HBT_OUT_HIZ [*2] |-> !high_switch_en && !low_switch_en;
    endproperty
    a_hiz_off: assert property (p_hiz_off)
        else $error("switch on while output off");
    property p_flag_keep;
        trip_compare_flag && sleep_request_pin && !clr_wr |=> trip_compare_flag;
    endproperty
    a_flag_keep: assert property (p_flag_keep)
        else $error("trip flag lost without clear");
    property p_flag_clr;
        clr_wr && !trip_comparator |=> !trip_compare_flag;
    endproperty
    a_flag_clr: assert property (p_flag_clr)
        else $error("trip flag not cleared");
    property p_flag_cause;
        $rose(trip_compare_flag) |-> $past(trip_comparator);
    endproperty
    a_flag_cause: assert property (p_flag_cause)
        else $error("trip flag set without comparator");
    property p_slope;
        SERIAL_VARIANT && wr_acc && paddr == HBT_OUTCFG_OFF |=> slope_select == $past(pwdata[2:0]);
    endproperty
    a_slope: assert property (p_slope)
        else $error("slope not applied");
    property p_trip_lvl;
        SERIAL_VARIANT && wr_acc && paddr == HBT_PROTCFG_OFF
            |=> trip_level_select == $past(pwdata[2:0]);
    endproperty
    a_trip_lvl: assert property (p_trip_lvl)
        else $error("trip level not applied");
    property p_ready;
        pready && !pslverr;
    endproperty
    a_ready: assert property (p_ready)
        else $error("apb answer not ready or error");
endmodule
bind hbt_bridge_ctrl hbt_bridge_ctrl_sva #(
    .SERIAL_VARIANT(SERIAL_VARIANT),
    .HAS_SLEEP_PIN(HAS_SLEEP_PIN)
) i_hbt_bridge_ctrl_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .sleep_request_pin(sleep_request_pin), .trip_comparator(trip_comparator),
    .high_switch_en(high_switch_en), .low_switch_en(low_switch_en),
    .bridge_state(bridge_state), .slope_select(slope_select),
    .trip_level_select(trip_level_select), .trip_compare_flag(trip_compare_flag)
);

// ===== hbt_bridge_ctrl_tb_top.sv
`timescale 1ns/1ps
module hbt_bridge_ctrl_tb_top;
    import hbt_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic sleep_pin = 1'b1;
    logic dis_pin = 1'b1;
    logic in_pin = 1'b0;
    logic oc = 1'b0;
    logic tc, hg, lg, hs, ls, osc, flag;
    hbt_out_e st;
    logic [2:0] slope, tlvl;
    int fails = 0;
    int checks_done = 0;
    int cyc = 0;
    int n;
    always #20 pclk = ~pclk;
    hbt_bridge_ctrl #(.SERIAL_VARIANT(1'b1), .HAS_SLEEP_PIN(1'b1)) i_hbt_bridge_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
        .sleep_request_pin(sleep_pin), .drive_disable_pin(dis_pin), .bridge_in_pin(in_pin),
        .output_slope_setting(3'h0), .trip_level_setting(3'h0), .hs_load_pin(1'b0),
        .trip_comparator(tc), .high_gate_on(hg), .low_gate_on(lg), .high_switch_en(hs),
        .low_switch_en(ls), .bridge_state(st), .slope_select(slope),
        .trip_level_select(tlvl), .osc_tick(osc), .trip_compare_flag(flag));
    hbt_power_stage i_hbt_power_stage (.pclk(pclk), .presetn(presetn), .high_switch_en(hs),
        .low_switch_en(ls), .over_current(oc), .high_gate_on(hg), .low_gate_on(lg),
        .trip_comparator(tc));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h00000000, q);
        chk(q & m, e);
    endtask
    // sample outputs away from the edge that updates them
    task automatic sst(input hbt_out_e e);
        repeat (4) @(posedge pclk);
        @(negedge pclk);
        chk(32'(st), 32'(e));
    endtask
    task automatic pins(input logic d, input logic i);
        @(posedge pclk);
        dis_pin <= d;
        in_pin <= i;
    endtask
    // wait out blanking, raise the overload, drop it once the output goes low
    task automatic trip();
        repeat (60) @(posedge pclk);
        oc <= 1'b1;
        n = 0;
        while (st !== HBT_OUT_LOW && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        oc <= 1'b0;
    endtask
    task end_sim;
        $display("checks=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ceiling well above the roughly 1300 cycles the tests need
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            fails++;
            end_sim();
        end
    end
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdc(HBT_OUTCFG_OFF, 32'hFFFFFFFF, HBT_OUTCFG_RST);
        rdc(HBT_PROTCFG_OFF, 32'hFFFFFFFF, HBT_PROTCFG_RST);
        rdc(HBT_STAT_OFF, 32'hFFFFFFFF, 32'h00000000);
        wr(8'h20, 32'hFFFFFFFF);
        rdc(8'h20, 32'hFFFFFFFF, 32'h00000000);
        sst(HBT_OUT_HIZ);
        $display("test reset done");
        for (int k = 0; k < 4; k++)
        begin
            pins(k[1], k[0]);
            sst(k[1] ? HBT_OUT_HIZ : (k[0] ? HBT_OUT_HIGH : HBT_OUT_LOW));
        end
        $display("test truth table done");
        wr(HBT_OUTCFG_OFF, 32'h00000045);
        // the write lands on the edge the task returns at; look after it settles
        @(negedge pclk);
        chk(32'(slope), 32'h00000005);
        wr(HBT_PROTCFG_OFF, 32'h00000007);
        @(negedge pclk);
        chk(32'(tlvl), 32'h00000007);
        n = 0;
        repeat (400)
        begin
            @(posedge pclk);
            n += int'(osc === 1'b1);
        end
        chk(32'(n > 0), 32'h00000001);
        $display("test config done");
        pins(1'b0, 1'b1);
        trip();
        chk(32'(n < 20), 32'h00000001);
        n = 0;
        while (st !== HBT_OUT_HIGH && n < 2000)
        begin
            @(posedge pclk);
            n++;
        end
        chk(32'(n >= (HBT_OFF_HOLD_INTERVAL_MIN_US * HBT_CLK_MHZ) - 2), 32'h00000001);
        chk(32'(n <= (HBT_OFF_HOLD_INTERVAL_MIN_US * HBT_CLK_MHZ) + 2), 32'h00000001);
        rdc(HBT_STAT_OFF, 32'h00000001, 32'h00000001);
        trip();
        repeat (20) @(posedge pclk);
        pins(1'b1, 1'b1);
        sst(HBT_OUT_HIZ);
        pins(1'b0, 1'b1);
        sst(HBT_OUT_HIGH);
        wr(HBT_CMD_OFF, 32'h00000004);
        @(negedge pclk);
        chk(32'(flag), 32'h00000000);
        $display("test trip done");
        wr(HBT_PROTCFG_OFF, 32'h00000040);
        repeat (60) @(posedge pclk);
        oc <= 1'b1;
        sst(HBT_OUT_HIGH);
        chk(32'(flag), 32'h00000000);
        @(posedge pclk);
        oc <= 1'b0;
        $display("test load mask done");
        wr(HBT_PROTCFG_OFF, 32'h00000000);
        pins(1'b0, 1'b0);
        wr(HBT_OVR_OFF, 32'h00000002);
        sst(HBT_OUT_LOW);
        wr(HBT_CMD_OFF, 32'h00000002);
        sst(HBT_OUT_HIGH);
        rdc(HBT_STAT_OFF, 32'h00000004, 32'h00000004);
        wr(HBT_PROTCFG_OFF, 32'h00000020);
        sst(HBT_OUT_LOW);
        pins(1'b0, 1'b1);
        sst(HBT_OUT_HIGH);
        wr(HBT_PROTCFG_OFF, 32'h00000000);
        wr(HBT_OVR_OFF, 32'h00000001);
        sst(HBT_OUT_HIZ);
        $display("test override done");
        @(posedge pclk);
        sleep_pin <= 1'b0;
        sst(HBT_OUT_HIZ);
        rdc(HBT_STAT_OFF, 32'h00000004, 32'h00000000);
        @(posedge pclk);
        sleep_pin <= 1'b1;
        sst(HBT_OUT_HIGH);
        $display("test sleep done");
        end_sim();
    end
endmodule

// ===== hbt_pkg.sv
package hbt_pkg;
    // apb register byte offsets
    localparam logic [7:0] HBT_CMD_OFF = 8'h00;
    localparam logic [7:0] HBT_OVR_OFF = 8'h04;
    localparam logic [7:0] HBT_OUTCFG_OFF = 8'h08;
    localparam logic [7:0] HBT_PROTCFG_OFF = 8'h0C;
    localparam logic [7:0] HBT_STAT_OFF = 8'h10;
    // command register fields
    localparam int HBT_UNLOCK_LSB = 0;
    localparam int HBT_UNLOCK_W = 2;
    localparam int HBT_CLR_BIT = 2;
    localparam logic [1:0] HBT_UNLOCK_KEY = 2'h2;
    // override register fields
    localparam int HBT_OVR_DIS_BIT = 0;
    localparam int HBT_OVR_IN_BIT = 1;
    // output config fields: slope[2:0], off-hold select[5:4], spread[6]
    localparam int HBT_SLOPE_LSB = 0;
    localparam int HBT_SLOPE_W = 3;
    localparam int HBT_OFF_HOLD_INTERVAL_LSB = 4;
    localparam int HBT_OFF_HOLD_INTERVAL_W = 2;
    localparam int HBT_SPREAD_BIT = 6;
    // protection config: trip level[2:0], dis sel[4], in sel[5], hs load[6]
    localparam int HBT_TRIP_LSB = 0;
    localparam int HBT_TRIP_W = 3;
    localparam int HBT_DIS_SEL_BIT = 4;
    localparam int HBT_IN_SEL_BIT = 5;
    localparam int HBT_HSLOAD_BIT = 6;
    // status fields
    localparam int HBT_ST_TRIP_BIT = 0;
    localparam int HBT_ST_HOLD_BIT = 1;
    localparam int HBT_ST_UNLK_BIT = 2;
    // reset values
    localparam logic [31:0] HBT_OUTCFG_RST = 32'h00000010;
    localparam logic [31:0] HBT_PROTCFG_RST = 32'h00000000;
    // timing
    localparam int HBT_CLK_MHZ = 25;
    localparam int HBT_OFF_HOLD_INTERVAL_MIN_US = 20;
    localparam int HBT_OFF_HOLD_INTERVAL_STEP_US = 10;
    localparam int HBT_OFF_HOLD_INTERVAL_HW_US = 30;
    localparam int HBT_BLANK_NS = 2000;
    localparam int HBT_BLANK_CYC = (HBT_BLANK_NS * HBT_CLK_MHZ + 999) / 1000;
    localparam int HBT_SLEW_BASE_CYC = 4;
    localparam int HBT_CNT_W = 11;
    // spread: +/-12 percent of a nominal divider, triangle stepped once per oscillator tick
    localparam int HBT_SPREAD_PCT = 12;
    localparam int HBT_SPREAD_KHZ = 1300;
    localparam int HBT_TRI_HALF_CYC = (HBT_CLK_MHZ * 1000) / (2 * HBT_SPREAD_KHZ);
    localparam int HBT_OSC_NOM = 100;
    localparam int HBT_OSC_DEV = HBT_OSC_NOM * HBT_SPREAD_PCT / 100;

    // bridge output state
    typedef enum logic [1:0] {HBT_OUT_HIZ, HBT_OUT_LOW, HBT_OUT_HIGH} hbt_out_e;

    // merged control inputs
    typedef struct packed {
        logic drive_disable;
        logic bridge_in;
    } hbt_ctl_s;
endpackage

// ===== hbt_power_stage.sv
`timescale 1ns/1ps
module hbt_power_stage (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // switch commands from the block
    input wire logic high_switch_en,
    input wire logic low_switch_en,
    // load current above trip level, set by the bench
    input wire logic over_current,
    // feedback to the block
    output logic high_gate_on,
    output logic low_gate_on,
    output logic trip_comparator
);
    logic [1:0] hs_dly;
    logic [1:0] ls_dly;
    // gates lag their enables by two cycles, so dead time has to be waited out
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hs_dly <= 2'h0;
            ls_dly <= 2'h0;
        end
        else
        begin
            hs_dly <= {hs_dly[0], high_switch_en};
            ls_dly <= {ls_dly[0], low_switch_en};
        end
    end
    assign high_gate_on = hs_dly[1];
    assign low_gate_on = ls_dly[1];
    // sensing only exists through a fully on high-side switch
    assign trip_comparator = over_current && high_gate_on;
endmodule
